// ===== core/opmc_pkg.sv
// Purpose: shared constants and types for the operating mode controller
// Assumes: single bus clock, 10 MHz
// Notes: command class codes are a local encoding of decoded debug commands
package opmc_pkg;

  // operating modes
  typedef enum logic [1:0] {
    OPMC_RUN,
    OPMC_BDM,
    OPMC_WAIT
  } opmc_mode_t;

  // decoded debug command kinds, as handed over by the serial receiver
  typedef enum logic [3:0] {
    OPMC_CMD_NONE,
    OPMC_CMD_MEM,
    OPMC_CMD_MEM_STAT,
    OPMC_CMD_DBGREG,
    OPMC_CMD_BACKGROUND,
    OPMC_CMD_CPUREG,
    OPMC_CMD_STEP,
    OPMC_CMD_GO
  } opmc_cmd_t;

  localparam logic [15:0] OPMC_RESET_VEC_HI = 16'hfffe;
  localparam logic [15:0] OPMC_RESET_VEC_LO = 16'hffff;
  localparam int unsigned OPMC_BIT_CYCLES = 16;
  localparam int unsigned OPMC_BIT_CNT_W = 4;
  localparam logic OPMC_PIN_RESET_DEBUG = 1'b1;
  localparam logic [1:0] OPMC_ERR_NONE = 2'h0;
  localparam logic [1:0] OPMC_ERR_STOPWAIT = 2'h1;
  localparam logic [1:0] OPMC_ERR_REJECT = 2'h2;

endpackage

// ===== core/opmc_strap.sv
// Purpose: catch the mode-select pin level at reset release
// Assumes: pin already synchronous to i_mclk
// Notes: captured by a clocked process, never loaded from the async reset
module opmc_strap
  import opmc_pkg::*;
(
  // clock and reset
  input wire logic i_mclk,
  input wire logic i_rst_n,
  input wire logic i_ce,
  // pin
  input wire logic i_mode_sel,
  // result
  output logic o_valid,
  output logic o_debug
);

  logic taken_q;
  logic taken_d;
  logic debug_q;
  logic debug_d;

  always_comb
  begin
    taken_d = taken_q;
    debug_d = debug_q;
    if (!taken_q)
    begin
      taken_d = 1'b1;
      debug_d = ~i_mode_sel; // [R3]
    end
  end

  always_ff @(posedge i_mclk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      taken_q <= 1'b0;
      debug_q <= 1'b0;
    end
    else if (i_ce)
    begin
      taken_q <= taken_d;
      debug_q <= debug_d;
    end
  end

  assign o_valid = taken_q;
  assign o_debug = debug_q;

endmodule

// ===== core/opmc_bittimer.sv
// Purpose: bit-time strobe for the single-wire debug link
// Assumes: debug controller clock equals i_mclk
// Notes: restarts on i_sync so bit edges line up with the link
module opmc_bittimer
  import opmc_pkg::*;
#(
  parameter int unsigned BIT_CYCLES = OPMC_BIT_CYCLES
)
(
  // clock and reset
  input wire logic i_mclk,
  input wire logic i_rst_n,
  input wire logic i_ce,
  // control
  input wire logic i_sync,
  // strobe
  output logic o_bit_tick
);

  localparam int unsigned W = $clog2(BIT_CYCLES);
  localparam logic [W-1:0] LAST = W'(BIT_CYCLES - 1);

  logic [W-1:0] cnt_q;
  logic [W-1:0] cnt_d;
  logic tick_q;
  logic tick_d;

  always_comb
  begin
    cnt_d = cnt_q + W'(1);
    tick_d = 1'b0;
    if (i_sync)
    begin
      cnt_d = '0;
    end
    else if (cnt_q == LAST)
    begin
      cnt_d = '0;
      tick_d = 1'b1; // [R18]
    end
  end

  always_ff @(posedge i_mclk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      cnt_q <= '0;
      tick_q <= 1'b0;
    end
    else if (i_ce)
    begin
      cnt_q <= cnt_d;
      tick_q <= tick_d;
    end
  end

  assign o_bit_tick = tick_q;

endmodule

// ===== core/opmc_core.sv
// Purpose: processor operating mode controller (run, debug halt, wait)
// Assumes: debug commands arrive decoded, one-cycle strobe with a kind code
// Notes: stop modes and the serial framing itself live elsewhere
//
// What this block does
// R1 - reset release with mode-select pin high enters run mode
// R2 - run after reset starts at the vector fetched from fffe:ffff
// R3 - pin low at reset release enters debug halt mode instead
// R4 - a BACKGROUND command over the debug wire enters debug halt
// R5 - the halt-to-debug instruction enters debug halt
// R6 - a breakpoint from debug controller or trace module enters debug halt
// R7 - in debug halt the cpu stays suspended awaiting commands
// R8 - non-intrusive commands run in both run and debug halt modes
// R9 - non-intrusive: memory, memory with status, controller registers, BACKGROUND
// R10 - halt-only commands execute only in debug halt, never in run
// R11 - halt-only: cpu register access, single step, resume to application
// R12 - the wait instruction gates the cpu clock off
// R13 - entering wait clears the interrupt mask flag
// R14 - an interrupt in wait wakes the cpu into interrupt stacking
// R15 - in wait only BACKGROUND and memory-with-status are honoured
// R16 - memory-with-status in wait does no access and reports stop/wait error
// R17 - BACKGROUND in wait wakes into debug halt
// R18 - one debug bit time is 16 debug controller clocks
// R19 - after any reset the shared port pin serves as mode select
// R20 - current mode is held in a state register, seeded by the strap
module opmc_core
  import opmc_pkg::*;
#(
  parameter int unsigned BIT_CYCLES = OPMC_BIT_CYCLES
)
(
  // clock, reset, enable
  input wire logic i_mclk,
  input wire logic i_rst_n,
  input wire logic i_ce,
  // shared pin as seen by the core
  input wire logic i_mode_sel,
  input wire logic i_link_sync,
  // cpu events
  input wire logic i_halt_insn,
  input wire logic i_wait_insn,
  input wire logic i_irq,
  input wire logic i_step_done,
  input wire logic i_brk_dbgctl,
  input wire logic i_brk_trace,
  // decoded debug command
  input wire logic i_cmd_valid,
  input wire opmc_cmd_t i_cmd,
  // cpu control
  output opmc_mode_t o_mode,
  output logic o_cpu_run,
  output logic o_cpu_clk_en,
  output logic o_fetch_reset_vec,
  output logic [15:0] o_vec_addr_hi,
  output logic [15:0] o_vec_addr_lo,
  output logic o_clr_int_mask,
  output logic o_irq_stack,
  // debug command execution
  output logic o_cmd_exec,
  output opmc_cmd_t o_cmd_exec_kind,
  output logic o_cmd_done,
  output logic [1:0] o_cmd_err,
  // pin function and link timing
  output logic o_pin_debug_fn,
  output logic o_bit_tick
);

  logic strap_valid;
  logic strap_debug;
  logic tick;

  opmc_strap opmc_strap_i (
    .i_mclk(i_mclk),
    .i_rst_n(i_rst_n),
    .i_ce(i_ce),
    .i_mode_sel(i_mode_sel),
    .o_valid(strap_valid),
    .o_debug(strap_debug)
  );

  opmc_bittimer #(
    .BIT_CYCLES(BIT_CYCLES)
  ) opmc_bittimer_i (
    .i_mclk(i_mclk),
    .i_rst_n(i_rst_n),
    .i_ce(i_ce),
    .i_sync(i_link_sync),
    .o_bit_tick(tick)
  );

  // mode state
  typedef enum logic [2:0] {
    OPMC_S_STRAP,
    OPMC_S_RUN,
    OPMC_S_BDM,
    OPMC_S_STEP,
    OPMC_S_WAIT
  } opmc_state_t;

  opmc_state_t state_q;
  opmc_state_t state_d;
  logic strap_seen_q;
  logic strap_seen_d;

  // registered outputs
  opmc_mode_t mode_q;
  opmc_mode_t mode_d;
  logic run_q;
  logic run_d;
  logic clk_en_q;
  logic clk_en_d;
  logic fetch_q;
  logic fetch_d;
  logic clr_mask_q;
  logic clr_mask_d;
  logic stack_q;
  logic stack_d;
  logic exec_q;
  logic exec_d;
  opmc_cmd_t kind_q;
  opmc_cmd_t kind_d;
  logic done_q;
  logic done_d;
  logic [1:0] err_q;
  logic [1:0] err_d;
  logic pin_fn_q;
  logic tick_q;
  // vector pointers kept in flops so every output is registered
  logic [15:0] vec_hi_q;
  logic [15:0] vec_lo_q;

  // command classes
  logic cmd_nonintr;
  logic cmd_haltonly;
  logic enter_bdm_evt;

  always_comb
  begin
    cmd_nonintr = (i_cmd == OPMC_CMD_MEM) || (i_cmd == OPMC_CMD_MEM_STAT) ||
      (i_cmd == OPMC_CMD_DBGREG) || (i_cmd == OPMC_CMD_BACKGROUND); // [R9]
    cmd_haltonly = (i_cmd == OPMC_CMD_CPUREG) || (i_cmd == OPMC_CMD_STEP) ||
      (i_cmd == OPMC_CMD_GO); // [R11]
    enter_bdm_evt = i_halt_insn || i_brk_dbgctl || i_brk_trace; // [R5] [R6]
  end

  always_comb
  begin
    state_d = state_q;
    strap_seen_d = strap_seen_q;
    fetch_d = 1'b0;
    clr_mask_d = 1'b0;
    stack_d = 1'b0;
    exec_d = 1'b0;
    kind_d = OPMC_CMD_NONE;
    done_d = 1'b0;
    err_d = OPMC_ERR_NONE;
    case (state_q)
      OPMC_S_STRAP:
      begin
        // wait one cycle so the strap flop holds the released-reset level
        if (strap_valid && !strap_seen_q)
        begin
          strap_seen_d = 1'b1;
        end
        else if (strap_seen_q)
        begin
          if (strap_debug)
          begin
            state_d = OPMC_S_BDM; // [R3] [R20]
          end
          else
          begin
            state_d = OPMC_S_RUN; // [R1] [R20]
            fetch_d = 1'b1; // [R2]
          end
        end
      end
      OPMC_S_RUN:
      begin
        if (i_cmd_valid && cmd_nonintr)
        begin
          exec_d = 1'b1; // [R8]
          kind_d = i_cmd;
          done_d = 1'b1;
        end
        else if (i_cmd_valid)
        begin
          done_d = 1'b1;
          err_d = OPMC_ERR_REJECT; // [R10]
        end
        if (i_cmd_valid && i_cmd == OPMC_CMD_BACKGROUND)
        begin
          state_d = OPMC_S_BDM; // [R4]
        end
        else if (enter_bdm_evt)
        begin
          state_d = OPMC_S_BDM; // [R5] [R6]
        end
        else if (i_wait_insn)
        begin
          state_d = OPMC_S_WAIT; // [R12]
          clr_mask_d = 1'b1; // [R13]
        end
      end
      OPMC_S_BDM:
      begin
        // cpu stays suspended; only commands move things here [R7]
        if (i_cmd_valid && (cmd_nonintr || cmd_haltonly))
        begin
          exec_d = 1'b1; // [R8] [R10]
          kind_d = i_cmd;
          done_d = 1'b1;
          if (i_cmd == OPMC_CMD_GO)
          begin
            state_d = OPMC_S_RUN; // [R11]
          end
          else if (i_cmd == OPMC_CMD_STEP)
          begin
            state_d = OPMC_S_STEP; // [R11]
          end
        end
        else if (i_cmd_valid)
        begin
          done_d = 1'b1;
          err_d = OPMC_ERR_REJECT;
        end
      end
      OPMC_S_STEP:
      begin
        // one instruction runs, then back to the halt
        // the host still gets an answer while the stepped instruction runs
        if (i_cmd_valid && cmd_nonintr)
        begin
          exec_d = 1'b1; // [R8]
          kind_d = i_cmd;
          done_d = 1'b1;
        end
        else if (i_cmd_valid)
        begin
          done_d = 1'b1;
          err_d = OPMC_ERR_REJECT; // [R10]
        end
        if (i_step_done)
        begin
          state_d = OPMC_S_BDM; // [R11]
        end
      end
      OPMC_S_WAIT:
      begin
        if (i_cmd_valid && i_cmd == OPMC_CMD_BACKGROUND)
        begin
          exec_d = 1'b1;
          kind_d = i_cmd;
          done_d = 1'b1;
          state_d = OPMC_S_BDM; // [R17] [R15]
        end
        else if (i_cmd_valid && i_cmd == OPMC_CMD_MEM_STAT)
        begin
          // no memory access is launched, only an error reply
          done_d = 1'b1;
          err_d = OPMC_ERR_STOPWAIT; // [R16] [R15]
        end
        else if (i_cmd_valid)
        begin
          done_d = 1'b1;
          err_d = OPMC_ERR_REJECT; // [R15]
        end
        // debug wake has priority over an interrupt in the same cycle
        if (!(i_cmd_valid && i_cmd == OPMC_CMD_BACKGROUND) && i_irq)
        begin
          state_d = OPMC_S_RUN; // [R14]
          stack_d = 1'b1; // [R14]
        end
      end
      default:
      begin
        state_d = OPMC_S_STRAP;
      end
    endcase
  end

  always_comb
  begin
    case (state_d)
      OPMC_S_RUN:
      begin
        mode_d = OPMC_RUN;
        run_d = 1'b1;
        clk_en_d = 1'b1;
      end
      OPMC_S_STEP:
      begin
        mode_d = OPMC_BDM;
        run_d = 1'b1;
        clk_en_d = 1'b1;
      end
      OPMC_S_WAIT:
      begin
        mode_d = OPMC_WAIT;
        run_d = 1'b0;
        clk_en_d = 1'b0; // [R12]
      end
      default:
      begin
        mode_d = OPMC_BDM;
        run_d = 1'b0; // [R7]
        clk_en_d = 1'b1;
      end
    endcase
  end

  always_ff @(posedge i_mclk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      state_q <= OPMC_S_STRAP;
      strap_seen_q <= 1'b0;
      mode_q <= OPMC_BDM;
      run_q <= 1'b0;
      clk_en_q <= 1'b1;
      fetch_q <= 1'b0;
      clr_mask_q <= 1'b0;
      stack_q <= 1'b0;
      exec_q <= 1'b0;
      kind_q <= OPMC_CMD_NONE;
      done_q <= 1'b0;
      err_q <= OPMC_ERR_NONE;
      pin_fn_q <= OPMC_PIN_RESET_DEBUG; // [R19]
      tick_q <= 1'b0;
      vec_hi_q <= OPMC_RESET_VEC_HI; // [R2]
      vec_lo_q <= OPMC_RESET_VEC_LO; // [R2]
    end
    else if (i_ce)
    begin
      state_q <= state_d;
      strap_seen_q <= strap_seen_d;
      mode_q <= mode_d;
      run_q <= run_d;
      clk_en_q <= clk_en_d;
      fetch_q <= fetch_d;
      clr_mask_q <= clr_mask_d;
      stack_q <= stack_d;
      exec_q <= exec_d;
      kind_q <= kind_d;
      done_q <= done_d;
      err_q <= err_d;
      pin_fn_q <= OPMC_PIN_RESET_DEBUG;
      tick_q <= tick; // [R18]
      vec_hi_q <= OPMC_RESET_VEC_HI;
      vec_lo_q <= OPMC_RESET_VEC_LO;
    end
  end

  assign o_mode = mode_q;
  assign o_cpu_run = run_q;
  assign o_cpu_clk_en = clk_en_q;
  assign o_fetch_reset_vec = fetch_q;
  assign o_vec_addr_hi = vec_hi_q;
  assign o_vec_addr_lo = vec_lo_q;
  assign o_clr_int_mask = clr_mask_q;
  assign o_irq_stack = stack_q;
  assign o_cmd_exec = exec_q;
  assign o_cmd_exec_kind = kind_q;
  assign o_cmd_done = done_q;
  assign o_cmd_err = err_q;
  assign o_pin_debug_fn = pin_fn_q;
  assign o_bit_tick = tick_q;

endmodule

// ===== verification/opmc_core_assertions.sv
// Purpose: temporal checks on the operating mode controller ports
// Assumes: one clock domain
// Notes: checks pause while clock enable is low, since state freezes then
module opmc_core_chk
  import opmc_pkg::*;
#(
  parameter int unsigned BIT_CYCLES = OPMC_BIT_CYCLES
)
(
  // clock and reset
  input wire logic i_mclk,
  input wire logic i_rst_n,
  input wire logic i_ce,
  // inputs watched
  input wire logic i_link_sync,
  input wire logic i_halt_insn,
  input wire logic i_wait_insn,
  input wire logic i_irq,
  input wire logic i_brk_dbgctl,
  input wire logic i_brk_trace,
  input wire logic i_cmd_valid,
  input wire opmc_cmd_t i_cmd,
  // outputs watched
  input wire opmc_mode_t o_mode,
  input wire logic o_cpu_run,
  input wire logic o_cpu_clk_en,
  input wire logic o_clr_int_mask,
  input wire logic o_irq_stack,
  input wire logic o_cmd_exec,
  input wire logic o_cmd_done,
  input wire logic [1:0] o_cmd_err,
  input wire logic o_bit_tick
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (!i_rst_n || !i_ce);

  property p_bg_run;
    o_mode == OPMC_RUN && i_cmd_valid && i_cmd == OPMC_CMD_BACKGROUND |=> o_mode == OPMC_BDM;
  endproperty
  a_bg_run: assert property (p_bg_run) else $error("bg cmd kept run");
  property p_halt;
    o_mode == OPMC_RUN && (i_halt_insn || i_brk_dbgctl || i_brk_trace) |=> o_mode == OPMC_BDM;
  endproperty
  a_halt: assert property (p_halt) else $error("halt event kept run");
  property p_run_rej;
    o_mode == OPMC_RUN && i_cmd_valid && i_cmd inside {OPMC_CMD_CPUREG, OPMC_CMD_STEP,
      OPMC_CMD_GO} |=> o_cmd_done && !o_cmd_exec && o_cmd_err == OPMC_ERR_REJECT;
  endproperty
  a_run_rej: assert property (p_run_rej) else $error("halt-only cmd ran in run");
  property p_wait_in;
    o_mode == OPMC_RUN && i_wait_insn && !i_cmd_valid && !i_halt_insn && !i_brk_dbgctl
      && !i_brk_trace |=> o_mode == OPMC_WAIT && !o_cpu_clk_en && o_clr_int_mask;
  endproperty
  a_wait_in: assert property (p_wait_in) else $error("bad wait entry");
  property p_irq;
    o_mode == OPMC_WAIT && i_irq && !i_cmd_valid |=> o_mode == OPMC_RUN && o_irq_stack;
  endproperty
  a_irq: assert property (p_irq) else $error("irq did not wake");
  property p_wstat;
    o_mode == OPMC_WAIT && i_cmd_valid && i_cmd == OPMC_CMD_MEM_STAT
      |=> o_cmd_done && !o_cmd_exec && o_cmd_err == OPMC_ERR_STOPWAIT;
  endproperty
  a_wstat: assert property (p_wstat) else $error("status cmd in wait");
  property p_wbg;
    o_mode == OPMC_WAIT && i_cmd_valid && i_cmd == OPMC_CMD_BACKGROUND |=> o_mode == OPMC_BDM;
  endproperty
  a_wbg: assert property (p_wbg) else $error("bg cmd in wait");
  property p_bdm;
    o_mode == OPMC_BDM && !o_cpu_run && !(i_cmd_valid && i_cmd == OPMC_CMD_STEP)
      |=> o_mode != OPMC_BDM || !o_cpu_run;
  endproperty
  a_bdm: assert property (p_bdm) else $error("cpu ran in halt");
  property p_tick;
    disable iff (!i_rst_n || !i_ce || i_link_sync) o_bit_tick |-> ##BIT_CYCLES o_bit_tick;
  endproperty
  a_tick: assert property (p_tick) else $error("bit period wrong");
endmodule

bind opmc_core opmc_core_chk #(.BIT_CYCLES(BIT_CYCLES)) opmc_core_chk_i (.*);

// ===== verification/opmc_host.sv
// Purpose: behavioural debug host driving decoded commands and the strap
// Assumes: tasks are called at a falling clock edge
// Notes: idle command code is inverted so a stale code never looks new
module opmc_host
  import opmc_pkg::*;
(
  // clock
  input wire logic i_mclk,
  // towards the device
  output logic o_mode_sel,
  output logic o_link_sync,
  output logic o_cmd_valid,
  output opmc_cmd_t o_cmd
);
  timeunit 1ns;
  timeprecision 1ns;
  initial
  begin
    o_mode_sel = 1'h1;
    o_link_sync = 1'h0;
    o_cmd_valid = 1'h0;
    o_cmd = OPMC_CMD_NONE;
  end
  // low through reset release forces halt, else pull-up level
  task strap(input logic lvl);
    o_mode_sel = lvl;
  endtask
  // gap idle cycles first; in wait only refusal tests send other kinds
  task send(input opmc_cmd_t c, input int gap);
    repeat (gap) @(negedge i_mclk);
    o_cmd_valid = 1'h1;
    o_cmd = c;
    @(negedge i_mclk);
    o_cmd_valid = 1'h0;
    o_cmd = opmc_cmd_t'(~c);
  endtask
  // frame start realigns bit timing
  task sync();
    o_link_sync = 1'h1;
    @(negedge i_mclk);
    o_link_sync = 1'h0;
  endtask
endmodule

// ===== verification/opmc_core_tb.sv
// Purpose: self-checking bench for the operating mode controller
// Assumes: inputs change at falling edges
// Notes: clock enable held high, so freeze is not exercised
module opmc_core_tb
  import opmc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic i_mclk = 1'h0;
  logic i_rst_n = 1'h0;
  logic i_ce = 1'h1;
  logic i_halt_insn = 1'h0;
  logic i_wait_insn = 1'h0;
  logic i_irq = 1'h0;
  logic i_step_done = 1'h0;
  logic i_brk_dbgctl = 1'h0;
  logic i_brk_trace = 1'h0;
  logic i_mode_sel, i_link_sync, i_cmd_valid;
  opmc_cmd_t i_cmd, o_cmd_exec_kind;
  opmc_mode_t o_mode;
  logic o_cpu_run, o_cpu_clk_en, o_fetch_reset_vec, o_clr_int_mask, o_irq_stack;
  logic o_cmd_exec, o_cmd_done, o_pin_debug_fn, o_bit_tick;
  logic [15:0] o_vec_addr_hi, o_vec_addr_lo;
  logic [1:0] o_cmd_err;
  int n_mismatch = 0;
  int compares = 0;

  always #50 i_mclk = ~i_mclk;

  opmc_core opmc_core_i (.*);
  opmc_host opmc_host_i (.i_mclk(i_mclk), .o_mode_sel(i_mode_sel),
    .o_link_sync(i_link_sync), .o_cmd_valid(i_cmd_valid), .o_cmd(i_cmd));

  task chk(input logic c, input string m);
    compares++;
    if (c !== 1'h1)
    begin
      n_mismatch++;
      $display("MISMATCH t=%0t %s", $time, m);
    end
  endtask
  task report_and_stop();
    $display("mismatches %0d compares %0d", n_mismatch, compares);
    if (n_mismatch == 0 && compares > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task cmd(input opmc_cmd_t c, input logic ex, input logic [1:0] er, input opmc_mode_t md);
    opmc_host_i.send(c, 1);
    chk(o_cmd_done === 1'h1 && o_cmd_exec === ex && o_cmd_err === er, "cmd answer");
    chk(o_cmd_exec_kind === (ex ? c : OPMC_CMD_NONE) && o_mode === md, "cmd kind or mode");
  endtask
  task automatic pulse(ref logic s);
    s = 1'h1;
    @(negedge i_mclk);
    s = 1'h0;
  endtask
  task do_reset(input logic lvl);
    opmc_host_i.strap(lvl);
    i_rst_n = 1'h0;
    repeat (10) @(negedge i_mclk);
    i_rst_n = 1'h1;
    repeat (3) @(negedge i_mclk);
    opmc_host_i.strap(1'h1);
  endtask

  task t_boot();
    do_reset(1'h1);
    chk(o_mode === OPMC_RUN && o_cpu_run === 1'h1, "run after reset");
    chk(o_fetch_reset_vec === 1'h1, "vector fetch");
    chk(o_vec_addr_hi === 16'hfffe && o_vec_addr_lo === 16'hffff, "vector addr");
    do_reset(1'h0);
    chk(o_mode === OPMC_BDM && o_cpu_run === 1'h0, "halt after reset");
    chk(o_fetch_reset_vec === 1'h0 && o_pin_debug_fn === 1'h1, "pin or fetch");
  endtask
  // halt mode first, then the same classes in run mode
  task t_cmds();
    for (int i = 1; i < 6; i++)
      cmd(opmc_cmd_t'(i), 1'h1, OPMC_ERR_NONE, OPMC_BDM);
    cmd(OPMC_CMD_NONE, 1'h0, OPMC_ERR_REJECT, OPMC_BDM);
    cmd(OPMC_CMD_STEP, 1'h1, OPMC_ERR_NONE, OPMC_BDM);
    chk(o_cpu_run === 1'h1, "step runs cpu");
    pulse(i_step_done);
    chk(o_cpu_run === 1'h0 && o_mode === OPMC_BDM, "step ends");
    cmd(OPMC_CMD_GO, 1'h1, OPMC_ERR_NONE, OPMC_RUN);
    for (int i = 1; i < 4; i++)
      cmd(opmc_cmd_t'(i), 1'h1, OPMC_ERR_NONE, OPMC_RUN);
    for (int i = 5; i < 8; i++)
      cmd(opmc_cmd_t'(i), 1'h0, OPMC_ERR_REJECT, OPMC_RUN);
    cmd(OPMC_CMD_BACKGROUND, 1'h1, OPMC_ERR_NONE, OPMC_BDM);
  endtask
  task t_events();
    for (int i = 0; i < 3; i++)
    begin
      cmd(OPMC_CMD_GO, 1'h1, OPMC_ERR_NONE, OPMC_RUN);
      case (i)
        0: pulse(i_halt_insn);
        1: pulse(i_brk_dbgctl);
        default: pulse(i_brk_trace);
      endcase
      chk(o_mode === OPMC_BDM && o_cpu_run === 1'h0, "halt event");
    end
  endtask
  task t_wait();
    cmd(OPMC_CMD_GO, 1'h1, OPMC_ERR_NONE, OPMC_RUN);
    pulse(i_wait_insn);
    chk(o_mode === OPMC_WAIT && o_cpu_clk_en === 1'h0, "wait entry");
    chk(o_clr_int_mask === 1'h1, "mask clear");
    cmd(OPMC_CMD_MEM_STAT, 1'h0, OPMC_ERR_STOPWAIT, OPMC_WAIT);
    cmd(OPMC_CMD_MEM, 1'h0, OPMC_ERR_REJECT, OPMC_WAIT);
    cmd(OPMC_CMD_GO, 1'h0, OPMC_ERR_REJECT, OPMC_WAIT);
    pulse(i_irq);
    chk(o_mode === OPMC_RUN && o_irq_stack === 1'h1 && o_cpu_clk_en === 1'h1, "wake");
    pulse(i_wait_insn);
    cmd(OPMC_CMD_BACKGROUND, 1'h1, OPMC_ERR_NONE, OPMC_BDM);
  endtask
  task t_tick();
    int n;
    n = 0;
    opmc_host_i.sync();
    while (o_bit_tick !== 1'h1 && n < 40)
    begin
      @(negedge i_mclk);
      n++;
    end
    n = 0;
    do
    begin
      @(negedge i_mclk);
      n++;
    end while (o_bit_tick !== 1'h1 && n < 40);
    chk(n == OPMC_BIT_CYCLES, "bit period");
  endtask

  initial
  begin
    t_boot();
    t_cmds();
    t_events();
    t_wait();
    t_tick();
    report_and_stop();
  end
  initial
  begin
    #100000;
    n_mismatch++;
    report_and_stop();
  end
endmodule
